/* core/sbp_map.svh */
// constants of the biphase programming command block
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH

// ==========================================================
// clock and host bit timing
`define SBP_CLK_KHZ        25000
`define SBP_H_BIT_MIN_US   972
`define SBP_H_BIT_MAX_US   1075
`define SBP_H_HALF_MIN_PCT 45
`define SBP_H_HALF_MAX_PCT 55
`define SBP_H_GAP_BITS     3

// ==========================================================
// sensor bit timing
`define SBP_S_BIT_US       1024
`define SBP_S_GAP_BITS     2
`define SBP_S_RESP_BITS    1

// ==========================================================
// counters and frame sizes
`define SBP_CNT_W          18
`define SBP_CNT_SAT        18'h3FFFF
`define SBP_HDR_BITS       5'h0A
`define SBP_WR_BITS        5'h1A
`define SBP_BITS_SAT       5'h1F

// ==========================================================
// answers and reset values
`define SBP_ACK_FRAME      17'h08000
`define SBP_ACK_LEN        5'h02
`define SBP_RPY_LEN        5'h11
`define SBP_BASE_RST       16'h0000

// ==========================================================
// permitted address windows, four of them, entry 0 lowest
`define SBP_WIN_LO         64'hC000_8000_0100_0000
`define SBP_WIN_HI         64'hC0FF_80FF_01FF_00FF

`endif

/* core/sbp_pkg.sv */
// shared types of the biphase programming command block
`default_nettype none
`include "sbp_map.svh"
package sbp_pkg;
    typedef logic [`SBP_CNT_W-1:0] sbp_cnt_t;
    typedef logic [15:0]           sbp_addr_t;
    typedef enum logic [2:0] {
        sbp_rd_abs   = 3'h0,
        sbp_rd_rel   = 3'h1,
        sbp_set_base = 3'h3,
        sbp_wr_byte  = 3'h5,
        sbp_wr_word  = 3'h6
    } sbp_cmd_t;
    typedef enum logic [3:0] {
        sbp_idle, sbp_decide, sbp_rdl, sbp_rdh, sbp_wrl, sbp_wrh,
        sbp_wait, sbp_tx, sbp_gap
    } sbp_state_t;
endpackage
`default_nettype wire

/* core/sbp_rx.sv */
// pulse-width receiver for host biphase frames
`timescale 1ns/1ps
`default_nettype none
`include "sbp_map.svh"
module sbp_rx #(
    parameter int unsigned BIT_MIN  = 1,
    parameter int unsigned BIT_MAX  = 2,
    parameter int unsigned HALF_MIN = 1,
    parameter int unsigned HALF_MAX = 1,
    parameter int unsigned GAP_MIN  = 3
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic line_in,
    input  wire logic mute,
    output logic      bit_stb,
    output logic      bit_val,
    output logic      frm_end,
    output logic      frm_err
);
    import sbp_pkg::*;

    // ==========================================================
    // edge timing
    sbp_cnt_t cnt;
    logic     prev;
    logic     in_frm;
    logic     half;
    logic     err;
    logic     mute_q;

    // the pin settles for one cycle after we release it, no false edge then
    wire edge_seen = (line_in != prev) && !mute && !mute_q;
    wire is_long   = (cnt >= sbp_cnt_t'(BIT_MIN)) && (cnt <= sbp_cnt_t'(BIT_MAX));
    wire is_short  = (cnt >= sbp_cnt_t'(HALF_MIN)) && (cnt <= sbp_cnt_t'(HALF_MAX));
    wire tmo       = in_frm && !edge_seen && (cnt >= sbp_cnt_t'(BIT_MAX));
    wire good_bit  = (is_long && !half) || (is_short && half);
    wire bad_pulse = !((is_long && !half) || is_short);
    // first edge of a frame is checked against the idle time before it
    wire gap_short = cnt < sbp_cnt_t'(GAP_MIN);
    wire next_err  = in_frm ? (err || bad_pulse) : gap_short;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev   <= 1'b1;
            mute_q <= 1'b0;
            cnt    <= `SBP_CNT_SAT;
        end else begin
            prev   <= line_in;
            mute_q <= mute;
            if (edge_seen)
                cnt <= '0;
            else if (mute)
                cnt <= `SBP_CNT_SAT;
            else if (cnt != `SBP_CNT_SAT)
                cnt <= cnt + 18'h00001;
        end
    end

    // ==========================================================
    // frame state; a dangling half bit at timeout is a width error
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_frm  <= 1'b0;
            half    <= 1'b0;
            err     <= 1'b0;
            bit_stb <= 1'b0;
            bit_val <= 1'b0;
            frm_end <= 1'b0;
            frm_err <= 1'b0;
        end else begin
            bit_stb <= edge_seen && in_frm && good_bit;
            bit_val <= is_short;
            frm_end <= tmo;
            if (tmo)
                frm_err <= err || half;
            if (mute || (edge_seen && !in_frm))
                half <= 1'b0;
            else if (edge_seen)
                half <= is_short && !half;
            if (mute)
                err <= 1'b0;
            else if (edge_seen)
                err <= next_err;
            if (mute)
                in_frm <= 1'b0;
            else if (edge_seen)
                in_frm <= 1'b1;
            else if (tmo)
                in_frm <= 1'b0;
        end
    end
endmodule // sbp_rx
`default_nettype wire

/* core/sbp_cmd.sv */
// command interpreter for biphase programming telegrams on the output pin
`timescale 1ns/1ps
`default_nettype none
`include "sbp_map.svh"
module sbp_cmd #(
    parameter int unsigned H_BIT_MIN  = (`SBP_H_BIT_MIN_US * `SBP_CLK_KHZ + 999) / 1000,
    parameter int unsigned H_BIT_MAX  = `SBP_H_BIT_MAX_US * `SBP_CLK_KHZ / 1000,
    parameter int unsigned H_HALF_MIN = (`SBP_H_BIT_MIN_US * `SBP_H_HALF_MIN_PCT
                                        * `SBP_CLK_KHZ + 99999) / 100000,
    parameter int unsigned H_HALF_MAX = `SBP_H_BIT_MAX_US * `SBP_H_HALF_MAX_PCT
                                        * `SBP_CLK_KHZ / 100000,
    parameter int unsigned H_GAP_MIN  = `SBP_H_GAP_BITS * H_BIT_MIN,
    parameter int unsigned S_BIT      = `SBP_S_BIT_US * `SBP_CLK_KHZ / 1000,
    parameter int unsigned S_HALF     = S_BIT / 2,
    parameter int unsigned S_GAP      = `SBP_S_GAP_BITS * S_BIT,
    parameter int unsigned S_RESP     = `SBP_S_RESP_BITS * S_BIT
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        line_in,
    output logic             line_out,
    output logic             line_oe,
    input  wire logic        ee_busy,
    input  wire logic        parity_fail,
    input  wire logic        checksum_fail,
    input  wire logic        err_clr,
    output logic             err_frame,
    output logic             err_parity,
    output logic             err_checksum,
    output logic             err_command,
    output logic             base_valid,
    output logic             mem_req,
    output logic             mem_we,
    output sbp_pkg::sbp_addr_t mem_addr,
    output logic [7:0]       mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        mem_fail
);
    import sbp_pkg::*;

    // ==========================================================
    // line receiver, muted while we drive the pin ourselves
    sbp_state_t st;
    sbp_state_t next_st;
    logic       rx_bit;
    logic       rx_val;
    logic       rx_end;
    logic       rx_ferr;

    wire mute = (st == sbp_tx) || (st == sbp_gap);

    sbp_rx #(
        .BIT_MIN  (H_BIT_MIN),
        .BIT_MAX  (H_BIT_MAX),
        .HALF_MIN (H_HALF_MIN),
        .HALF_MAX (H_HALF_MAX),
        .GAP_MIN  (H_GAP_MIN)
    ) u_rx (
        .clk     (clk),
        .rst_n   (rst_n),
        .line_in (line_in),
        .mute    (mute),
        .bit_stb (rx_bit),
        .bit_val (rx_val),
        .frm_end (rx_end),
        .frm_err (rx_ferr)
    );

    // ==========================================================
    // frame capture: start, code, address, dummy, then payload
    logic [4:0]  nbits;
    logic [25:0] sh;

    wire       is_rd  = nbits == `SBP_HDR_BITS;
    wire       is_wr  = nbits == `SBP_WR_BITS;
    wire [9:0] hdr    = is_wr ? sh[25:16] : sh[9:0];
    // too few or too many bits land here as a count mismatch
    wire       fr_bad = rx_ferr || !(is_rd || is_wr) || hdr[9] || hdr[0];
    wire       take   = rx_end && (st == sbp_idle);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh    <= '0;
            nbits <= '0;
        end else if (rx_end) begin
            nbits <= '0;
        end else if (rx_bit && (nbits != `SBP_BITS_SAT)) begin
            sh    <= {sh[24:0], rx_val};
            nbits <= nbits + 5'h01;
        end
    end

    logic [2:0]  cmd_q;
    logic [4:0]  addr_q;
    logic [15:0] pay_q;
    logic        wr_q;
    logic        ferr_q;
    logic        perr_q;
    logic        cerr_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q  <= '0;
            addr_q <= '0;
            pay_q  <= '0;
            wr_q   <= 1'b0;
            ferr_q <= 1'b0;
            perr_q <= 1'b0;
            cerr_q <= 1'b0;
        end else if (take) begin
            cmd_q  <= hdr[8:6];
            addr_q <= hdr[5:1];
            pay_q  <= sh[15:0];
            wr_q   <= is_wr;
            ferr_q <= fr_bad;
            perr_q <= parity_fail;
            cerr_q <= checksum_fail;
        end
    end

    // ==========================================================
    // decode and checks
    sbp_addr_t base;

    wire c_abs  = cmd_q == sbp_rd_abs;
    wire c_rel  = cmd_q == sbp_rd_rel;
    wire c_set  = cmd_q == sbp_set_base;
    wire c_wrb  = cmd_q == sbp_wr_byte;
    wire c_wrw  = cmd_q == sbp_wr_word;
    wire c_rd   = c_abs || c_rel;
    wire c_wr   = c_wrb || c_wrw;
    wire known  = c_rd || c_set || c_wr;
    wire typ_ok = (c_rd && !wr_q) || ((c_set || c_wr) && wr_q);

    // absolute reads only reach the lowest 33 bytes
    wire [15:0] eff  = c_abs ? {11'h000, addr_q} : base + {11'h000, addr_q};
    wire [15:0] eff1 = eff + 16'h0001;

    localparam logic [63:0] WIN_LO = `SBP_WIN_LO;
    localparam logic [63:0] WIN_HI = `SBP_WIN_HI;
    logic [3:0] hit_lo;
    logic [3:0] hit_hi;

    for (genvar i = 0; i < 4; i++) begin : g_win
        assign hit_lo[i] = (eff >= WIN_LO[i*16 +: 16]) && (eff <= WIN_HI[i*16 +: 16]);
        assign hit_hi[i] = (eff1 >= WIN_LO[i*16 +: 16]) && (eff1 <= WIN_HI[i*16 +: 16]);
    end

    wire need_hi  = c_rd || c_wrw;
    wire perm     = (|hit_lo) && ((|hit_hi) || !need_hi);
    wire no_base  = (c_rel || c_wr) && !base_valid;
    wire ee_block = c_wr && ee_busy;
    wire exec_bad = !typ_ok || no_base || (!c_set && !perm) || ee_block;
    wire cmd_err  = !known || exec_bad;
    wire comm_err = ferr_q || perr_q || cerr_q;
    wire any_err  = comm_err || cmd_err;
    wire mfail    = mem_req && mem_fail;

    // ==========================================================
    // sequencer
    logic [16:0] tx_sh;
    logic [4:0]  tx_len;
    logic [4:0]  tx_idx;
    sbp_cnt_t    tm;
    logic        tx_out;

    wire resp_go  = tm == sbp_cnt_t'(S_RESP - 1);
    wire bit_last = tm == sbp_cnt_t'(S_BIT - 1);
    wire gap_done = tm == sbp_cnt_t'(S_GAP - 1);
    wire at_bound = (st == sbp_tx) && (tm == '0);
    wire at_mid   = (st == sbp_tx) && (tm == sbp_cnt_t'(S_HALF)) && tx_sh[16];
    wire tx_done  = at_bound && (tx_idx == tx_len);

    always_comb begin
        next_st = st;
        case (st)
            sbp_idle:
                if (take)
                    next_st = sbp_decide;
            sbp_decide:
                if (any_err)
                    next_st = sbp_idle;
                else if (c_set)
                    next_st = sbp_wait;
                else if (c_rd)
                    next_st = sbp_rdl;
                else
                    next_st = sbp_wrl;
            sbp_rdl:
                next_st = mem_fail ? sbp_idle : sbp_rdh;
            sbp_rdh:
                next_st = mem_fail ? sbp_idle : sbp_wait;
            sbp_wrl:
                if (mem_fail)
                    next_st = sbp_idle;
                else
                    next_st = c_wrw ? sbp_wrh : sbp_wait;
            sbp_wrh:
                next_st = mem_fail ? sbp_idle : sbp_wait;
            sbp_wait:
                if (resp_go)
                    next_st = sbp_tx;
            sbp_tx:
                if (tx_done)
                    next_st = sbp_gap;
            sbp_gap:
                if (gap_done)
                    next_st = sbp_idle;
            default:
                next_st = sbp_idle;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            st <= sbp_idle;
        else
            st <= next_st;
    end

    // ==========================================================
    // base address; the lock stays until the next reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            base       <= `SBP_BASE_RST;
            base_valid <= 1'b0;
        end else if ((st == sbp_decide) && !any_err && c_set) begin
            base       <= pay_q;
            base_valid <= 1'b1;
        end
    end

    // ==========================================================
    // memory port, read data is taken in the cycle of the request
    logic [7:0] rd_lo;

    assign mem_req = (st == sbp_rdl) || (st == sbp_rdh) || (st == sbp_wrl) || (st == sbp_wrh);
    assign mem_we  = (st == sbp_wrl) || (st == sbp_wrh);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr  <= '0;
            mem_wdata <= '0;
            rd_lo     <= '0;
        end else if (st == sbp_decide) begin
            mem_addr  <= eff;
            mem_wdata <= pay_q[7:0];
        end else if ((st == sbp_rdl) || (st == sbp_wrl)) begin
            mem_addr  <= eff1;
            mem_wdata <= pay_q[15:8];
            rd_lo     <= mem_rdata;
        end
    end

    // ==========================================================
    // answer shifter and line driver
    wire load = (next_st == sbp_wait) && (st != sbp_wait);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh  <= '0;
            tx_len <= '0;
            tx_idx <= '0;
        end else if (load) begin
            tx_sh  <= (st == sbp_rdh) ? {1'b0, mem_rdata, rd_lo} : `SBP_ACK_FRAME;
            tx_len <= (st == sbp_rdh) ? `SBP_RPY_LEN : `SBP_ACK_LEN;
            tx_idx <= '0;
        end else if ((st == sbp_tx) && bit_last) begin
            tx_sh  <= {tx_sh[15:0], 1'b0};
            tx_idx <= tx_idx + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            tm <= '0;
        else if ((st != next_st) || ((st == sbp_tx) && bit_last))
            tm <= '0;
        else if ((st == sbp_wait) || (st == sbp_tx) || (st == sbp_gap))
            tm <= tm + 18'h00001;
    end

    // line rests high while released, so the first boundary pulls it low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            tx_out <= 1'b1;
        else if ((st == sbp_gap) && gap_done)
            tx_out <= 1'b1;
        else if (at_bound || at_mid)
            tx_out <= ~tx_out;
    end

    assign line_out = tx_out;
    assign line_oe  = mute;

    // ==========================================================
    // error log, a new event wins over a clear in the same cycle
    wire set_frm = (st == sbp_decide) && ferr_q;
    wire set_par = (st == sbp_decide) && perr_q;
    wire set_chk = (st == sbp_decide) && cerr_q;
    wire set_cmd = ((st == sbp_decide) && cmd_err) || mfail;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_frame    <= 1'b0;
            err_parity   <= 1'b0;
            err_checksum <= 1'b0;
            err_command  <= 1'b0;
        end else begin
            err_frame    <= set_frm || (err_frame && !err_clr);
            err_parity   <= set_par || (err_parity && !err_clr);
            err_checksum <= set_chk || (err_checksum && !err_clr);
            err_command  <= set_cmd || (err_command && !err_clr);
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_unknown_silent:
        assert property ((st == sbp_decide) && !known |=> (st == sbp_idle) ##1 !line_oe)
            else $error("unknown code was answered");
    a_base_load:
        assert property ((st == sbp_decide) && !any_err && c_set
                         |=> base == $past(pay_q) && base_valid && (st == sbp_wait))
            else $error("base not loaded");
    a_abs_addr:
        assert property ((st == sbp_decide) && !any_err && c_abs
                         |=> mem_addr == {11'h000, $past(addr_q)} ##1 mem_addr == eff1)
            else $error("absolute address wrong");
    a_rel_addr:
        assert property ((st == sbp_decide) && !any_err && c_rel
                         |=> mem_addr == $past(base) + {11'h000, $past(addr_q)})
            else $error("relative address wrong");
    a_reply_order:
        assert property ((st == sbp_rdh) && !mem_fail
                         |=> tx_sh == {1'b0, $past(mem_rdata), $past(rd_lo)})
            else $error("reply bytes misplaced");
    a_wr_byte:
        assert property ((st == sbp_wrl) |-> mem_we && mem_wdata == pay_q[7:0])
            else $error("byte write data wrong");
    a_wr_word:
        assert property ((st == sbp_wrh)
                         |-> mem_wdata == pay_q[15:8] && mem_addr == $past(mem_addr) + 16'h0001)
            else $error("word write high byte wrong");
    a_base_lock:
        assert property (mem_req && (c_rel || c_wr) |-> base_valid)
            else $error("base command ran before base set");
    a_ee_discard:
        assert property ((st == sbp_decide) && c_wr && ee_busy |=> !mem_we [*2])
            else $error("write during eeprom programming");
    a_err_silent:
        assert property ((st == sbp_decide) && any_err |=> (st == sbp_idle) && !line_oe)
            else $error("answer despite error");
    a_frame_log:
        assert property (take && fr_bad |-> ##2 err_frame)
            else $error("frame error not logged");
    a_resp_start:
        assert property ((st == sbp_wait) && resp_go |=> line_oe ##1 (line_oe && !line_out))
            else $error("reply did not start");
    a_tx_gap:
        assert property ((st == sbp_gap) && !gap_done |=> (st == sbp_gap))
            else $error("idle gap cut short");
    a_mid_toggle:
        assert property (at_mid |=> line_out != $past(line_out))
            else $error("missing mid-bit toggle");

    c_set_base:   cover property ((st == sbp_decide) && !any_err && c_set);
    c_read_reply: cover property ((st == sbp_tx) && (tx_len == `SBP_RPY_LEN) && tx_done);
    c_word_write: cover property ((st == sbp_wrh) && !mem_fail);
    c_ee_discard: cover property ((st == sbp_decide) && c_wr && ee_busy);
endmodule // sbp_cmd
`default_nettype wire

/* tb/sbp_host_model.sv */
// host programmer model that sends frames and reads the sensor reply
`timescale 1ns/1ps
`default_nettype none
module sbp_host_model (
    input  wire logic clk,
    input  wire logic line_out,
    input  wire logic line_oe,
    output logic      host_drv
);
    initial host_drv = 1'b1;
    // =====
    // sender: 21-cycle bits, halves of 10 and 11
    task automatic send(input logic [25:0] b, input int n);
        repeat (70) @(posedge clk);
        host_drv <= ~host_drv;
        for (int i = n - 1; i >= 0; i--) begin
            if (b[i]) begin
                repeat (10) @(posedge clk);
                host_drv <= ~host_drv;
                repeat (11) @(posedge clk);
            end else begin
                repeat (21) @(posedge clk);
            end
            host_drv <= ~host_drv;
        end
    endtask
    // =====
    // reader: fixed 20-cycle sensor bits, samples a quarter in
    task automatic get(input int nb, output logic [16:0] v, output int lat, output int oe_n);
        logic a;
        v = '0;
        lat = 0;
        oe_n = 0;
        while (line_oe !== 1'b1 && lat < 150) begin
            @(posedge clk);
            lat++;
        end
        if (line_oe !== 1'b1) return;
        host_drv <= 1'b1; // ignored while the sensor drives, keeps idle high
        while (line_out === 1'b1 && oe_n < 40) begin
            @(posedge clk);
            oe_n++;
        end
        repeat (5) @(posedge clk);
        for (int i = nb - 1; i >= 0; i--) begin
            a = line_out;
            repeat (10) @(posedge clk);
            v[i] = (a !== line_out);
            repeat (10) @(posedge clk);
        end
        oe_n += nb * 20 + 5;
        while (line_oe === 1'b1 && oe_n < 900) begin
            @(posedge clk);
            oe_n++;
        end
    endtask
endmodule // sbp_host_model
`default_nettype wire

/* tb/test_sbp_cmd.sv */
// self-checking bench of the biphase command interpreter
`timescale 1ns/1ps
`default_nettype none
module test_sbp_cmd;
    import sbp_pkg::*;
    typedef struct packed {logic [25:0] b; int n; int kind; logic [16:0] d;} sbp_row_t;
    logic        clk, rst_n, ee_busy, parity_fail, checksum_fail, err_clr, mem_fail;
    logic        line_out, line_oe, host_drv, base_valid, mem_req, mem_we;
    logic        err_frame, err_parity, err_checksum, err_command;
    sbp_addr_t   mem_addr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem [0:65535];
    logic [16:0] got;
    int          num_errors, n_checks, lat, oe_n;
    sbp_row_t    rows[$];
    wire logic   line_in = line_oe ? line_out : host_drv;
    wire logic [7:0] mem_rdata = mem[mem_addr];
    // =====
    // design, host and byte memory
    sbp_cmd #(.H_BIT_MIN(20), .H_BIT_MAX(22), .H_HALF_MIN(9), .H_HALF_MAX(12),
        .S_BIT(20)) dut (
        .clk(clk), .rst_n(rst_n), .line_in(line_in), .line_out(line_out),
        .line_oe(line_oe), .ee_busy(ee_busy), .parity_fail(parity_fail),
        .checksum_fail(checksum_fail), .err_clr(err_clr), .err_frame(err_frame),
        .err_parity(err_parity), .err_checksum(err_checksum), .err_command(err_command),
        .base_valid(base_valid), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_fail(mem_fail));
    sbp_host_model host (.clk(clk), .line_out(line_out), .line_oe(line_oe),
        .host_drv(host_drv));
    always @(posedge clk) if (mem_req && mem_we) mem[mem_addr] <= mem_wdata;
    // =====
    // helpers
    function automatic logic [7:0] pv(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    function automatic sbp_row_t mk(input logic [2:0] c, input logic [4:0] a,
        input logic w, input logic [15:0] p, input int k);
        mk.b = w ? {1'b0, c, a, 1'b0, p} : {16'h0000, 1'b0, c, a, 1'b0};
        mk.n = w ? 26 : 10;
        mk.kind = k;
        mk.d = (k == 2) ? {1'b0, p} : 17'h00001;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input sbp_row_t r);
        host.send(r.b, r.n);
        host.get(r.kind == 2 ? 17 : 2, got, lat, oe_n);
        chk(32'(lat < 150), 32'(r.kind != 0));
        if (r.kind != 0) begin
            chk(32'(got), 32'(r.d));
            chk(32'(lat >= 20 && lat <= 100), 32'h1);
            chk(32'(oe_n >= (r.kind == 2 ? 380 : 80)), 32'h1);
        end
        $display("telegram %h done, errors %0d", r.b, num_errors);
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // =====
    // clock, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (80000) @(posedge clk);
        num_errors++;
        final_report();
    end
    initial begin
        sbp_row_t fr;
        {rst_n, ee_busy, parity_fail, checksum_fail, err_clr, mem_fail} = 6'h00;
        for (int i = 0; i < 65536; i++) mem[i] = pv(16'(i));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 chk({line_oe, line_out, base_valid, err_frame, err_parity, err_checksum,
            err_command, mem_req, mem_we}, 32'h080);
        rows = '{mk(3'h1, 5'h00, 0, 16'h0000, 0), mk(3'h5, 5'h01, 1, 16'h00AA, 0),
            mk(3'h0, 5'h02, 0, {pv(16'h0003), pv(16'h0002)}, 2),
            mk(3'h0, 5'h1F, 0, {pv(16'h0020), pv(16'h001F)}, 2),
            mk(3'h3, 5'h00, 1, 16'h8000, 1), mk(3'h5, 5'h04, 1, 16'h12A5, 1),
            mk(3'h6, 5'h06, 1, 16'hBEEF, 1),
            mk(3'h1, 5'h04, 0, {pv(16'h8005), 8'hA5}, 2), mk(3'h1, 5'h06, 0, 16'hBEEF, 2),
            mk(3'h2, 5'h00, 0, 16'h0000, 0), mk(3'h4, 5'h01, 1, 16'h0011, 0),
            mk(3'h7, 5'h00, 0, 16'h0000, 0),
            mk(3'h3, 5'h00, 1, 16'h0200, 1), mk(3'h1, 5'h01, 0, 16'h0000, 0)};
        foreach (rows[i]) run(rows[i]);
        chk(32'(base_valid), 32'h1);
        chk(32'(err_command), 32'h1);
        run(mk(3'h3, 5'h00, 1, 16'h8000, 1));
        ee_busy <= 1'b1;
        run(mk(3'h5, 5'h00, 1, 16'h0033, 0));
        ee_busy <= 1'b0;
        run(mk(3'h1, 5'h00, 0, {pv(16'h8001), pv(16'h8000)}, 2));
        err_clr <= 1'b1;
        @(posedge clk);
        err_clr <= 1'b0;
        @(posedge clk);
        #1 chk({err_frame, err_parity, err_checksum, err_command}, 32'h0);
        @(posedge clk);
        for (int k = 0; k < 3; k++) begin
            {mem_fail, checksum_fail, parity_fail} <= 3'(1 << k);
            run(mk(3'h0, 5'h02, 0, 16'h0000, 0));
        end
        {mem_fail, checksum_fail, parity_fail} <= 3'h0;
        chk({err_parity, err_checksum, err_command}, 32'h7);
        fr = mk(3'h0, 5'h02, 0, 16'h0000, 0);
        fr.b[9] = 1'b1;
        run(fr);
        chk(32'(err_frame), 32'h1);
        final_report();
    end
endmodule // test_sbp_cmd
`default_nettype wire
